/* File: pomc_assertions.sv */
`timescale 1ns/1ps
module pomc_assertions (
   // Clock, reset and bus handshake
   input wire       CLOCK,
   input wire       NRST,
   input wire       PSEL,
   input wire       PENABLE,
   input wire       PREADY,
   // Block controls and mode
   input wire       MII_DRIVE_EN,
   input wire       MII_RX_FORCE_LOW,
   input wire       PCS_TX_EN,
   input wire       PCS_RX_EN,
   input wire       ACT_DETECT_EN,
   input wire       OSC_EN,
   input wire       CORE_REG_EN,
   input wire       REGULATOR_INHIBIT_OUT,
   input wire       INT_OUT_EN,
   input wire [3:0] MODE_CODE
);
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!NRST);
   // Controls lead MODE_CODE by one cycle, hence the past values
   wire on_m = (MODE_CODE == 4'h3) || (MODE_CODE == 4'hB);
   wire sb   = (MODE_CODE == 4'hC);
   wire sl   = (MODE_CODE == 4'hA);
   wire ds   = (MODE_CODE == 4'h1);
   property p_path_on; on_m |-> $past(PCS_TX_EN) && $past(PCS_RX_EN) && $past(MII_DRIVE_EN); endproperty
   a_path_on: assert property (p_path_on) else $error("Data path off in active mode");
   property p_path_off; (PCS_TX_EN || PCS_RX_EN || MII_DRIVE_EN) |=> on_m; endproperty
   a_path_off: assert property (p_path_off) else $error("Data path on in idle mode");
   property p_rx_low; MII_RX_FORCE_LOW |=> sb; endproperty
   a_rx_low: assert property (p_rx_low) else $error("Receive outputs forced outside Standby");
   property p_standby; sb |-> $past(MII_RX_FORCE_LOW) && !$past(OSC_EN) && $past(ACT_DETECT_EN); endproperty
   a_standby: assert property (p_standby) else $error("Standby controls wrong");
   property p_sleep; sl |-> !$past(CORE_REG_EN) && !$past(REGULATOR_INHIBIT_OUT) && !$past(INT_OUT_EN); endproperty
   a_sleep: assert property (p_sleep) else $error("Sleep controls wrong");
   property p_disable; ds |-> !$past(OSC_EN) && !$past(CORE_REG_EN) && !$past(INT_OUT_EN); endproperty
   a_disable: assert property (p_disable) else $error("Disable controls wrong");
   property p_act; ACT_DETECT_EN |=> sb || sl; endproperty
   a_act: assert property (p_act) else $error("Activity detect on in wrong mode");
   property p_inh; (on_m || sb) |-> $past(REGULATOR_INHIBIT_OUT); endproperty
   a_inh: assert property (p_inh) else $error("Inhibit output released too early");
   property p_req_hold; sb == 1'b0 && MODE_CODE == 4'hB && $past(MODE_CODE) != 4'hB |-> (!sl && MODE_CODE != 4'h9)[*8]; endproperty
   a_req_hold: assert property (p_req_hold) else $error("Sleep Request left too early");
   property p_ready; PSEL && !PENABLE |=> PREADY; endproperty
   a_ready: assert property (p_ready) else $error("No answer in access cycle");
endmodule // pomc_assertions

bind pomc_top pomc_assertions i_chk (
   .CLOCK(CLOCK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY),
   .MII_DRIVE_EN(MII_DRIVE_EN), .MII_RX_FORCE_LOW(MII_RX_FORCE_LOW), .PCS_TX_EN(PCS_TX_EN),
   .PCS_RX_EN(PCS_RX_EN), .ACT_DETECT_EN(ACT_DETECT_EN), .OSC_EN(OSC_EN),
   .CORE_REG_EN(CORE_REG_EN), .REGULATOR_INHIBIT_OUT(REGULATOR_INHIBIT_OUT),
   .INT_OUT_EN(INT_OUT_EN), .MODE_CODE(MODE_CODE)
);

/* File: pomc_map.vh */
// Overview of operation
// - Coding sublayers and data interface active only in Normal and Sleep Request.
// - Standby drives receive data, error and valid low; other pins inputs.
// - Sleep keeps management reachable, restricted to mode control and wake-up.
// - Oscillator off in Standby and Disable, and in Sleep unless held; else follows source.
// - Core regulator on when supply select low, always off in Sleep and Disable.
// - Inhibit output active Normal/Standby/Sleep Request, off in Sleep, configurable in Disable.
// - Coinciding causes resolved by fixed priority, commands and wake-ups after supply and pin events, timeouts last.
// - Normal to Sleep Request on command 1011 or idle power-down timeout.
// - Normal to Sleep Request on low-power code with handshake after timeout.
// - Sleep Request back to Normal on command 0011 or wake-up request.
// - Without acknowledge enable, detected data returns Sleep Request to Normal.
// - With acknowledge enable, command or wake returns only before ack timeout.
// - After request timeout go Silent if signalling enabled, else Sleep.
// - Silent returns to Normal once request timer exceeds its timeout.
// - Undervoltage timing arms after supplies present; persisting undervoltage enters Sleep.
// - In Sleep only mode read or Standby command 1100 take effect.
// - Silent enters Sleep as soon as the line becomes quiet.
`ifndef POMC_MAP_VH
`define POMC_MAP_VH

`define POMC_ADDR_W        8
`define POMC_OFS_MODE      8'h00
`define POMC_OFS_CFG       8'h04
`define POMC_OFS_STATUS    8'h08

`define POMC_CMD_NORMAL    4'h3
`define POMC_CMD_SLEEPREQ  4'hB
`define POMC_CMD_STANDBY   4'hC

`define POMC_CODE_OFF      4'h0
`define POMC_CODE_NORMAL   4'h3
`define POMC_CODE_STANDBY  4'hC
`define POMC_CODE_SLEEPREQ 4'hB
`define POMC_CODE_SILENT   4'h9
`define POMC_CODE_SLEEP    4'hA
`define POMC_CODE_DISABLE  4'h1

`define POMC_CFG_IDLE_PD   0
`define POMC_CFG_LPS_DIS   1
`define POMC_CFG_LPS_HS    2
`define POMC_CFG_FWD_WAKE  3
`define POMC_CFG_CORE_SEL  4
`define POMC_CFG_INH_DIS   5
`define POMC_CFG_KEEP_CLK  6
`define POMC_CFG_CLK_LO    7
`define POMC_CFG_CLK_HI    8
`define POMC_CFG_SLP_ACK   9
`define POMC_CFG_W         10
`define POMC_CFG_RST       10'h000

`define POMC_CLK_MHZ       200
`define POMC_REQ_NS        2000000
`define POMC_ACK_NS        1000000
`define POMC_IDLE_NS       10000000
`define POMC_UV_NS         100000000
`define POMC_REQ_CYC       ((`POMC_REQ_NS / 1000) * `POMC_CLK_MHZ)
`define POMC_ACK_CYC       ((`POMC_ACK_NS / 1000) * `POMC_CLK_MHZ)
`define POMC_IDLE_CYC      ((`POMC_IDLE_NS / 1000) * `POMC_CLK_MHZ)
`define POMC_UV_CYC        ((`POMC_UV_NS / 1000) * `POMC_CLK_MHZ)

`endif

/* File: pomc_partner.sv */
`timescale 1ns/1ps
module pomc_partner (
   // Clock and scenario select
   input wire        clk,
   input wire  [2:0] lnk,
   // Local transmitter as seen on the line
   input wire        tx_on,
   // Line status towards the block
   output wire       rx_dv,
   output wire       wur,
   output wire       lps,
   output wire       frames,
   output wire       activity,
   output wire       quiet
);
   // Select: 0 idle, 1 busy, 2 low-power code, 3 wake request, 4 data
   logic [2:0] sil_reg = 3'h0;
   // Quiet only some cycles after our transmitter stops, never at once
   always @(posedge clk) sil_reg <= tx_on ? 3'h0 : sil_reg + {2'h0, sil_reg != 3'h7};
   assign rx_dv    = (lnk == 3'h4);
   assign wur      = (lnk == 3'h3);
   assign lps      = (lnk == 3'h2);
   assign frames   = (lnk == 3'h1) || rx_dv;
   assign activity = (lnk == 3'h1);
   assign quiet    = !frames && (sil_reg > 3'h3);
endmodule // pomc_partner

/* File: pomc_top.v */
// The register addresses and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "pomc_map.vh"
module pomc_top #(
   parameter [31:0] REQ_CYC  = `POMC_REQ_CYC,
   parameter [31:0] ACK_CYC  = `POMC_ACK_CYC,
   parameter [31:0] IDLE_CYC = `POMC_IDLE_CYC,
   parameter [31:0] UV_CYC   = `POMC_UV_CYC
) (
   // Clock and reset
   input  wire        CLOCK,
   input  wire        NRST,
   // APB slave
   input  wire        PSEL,
   input  wire        PENABLE,
   input  wire        PWRITE,
   input  wire [7:0]  PADDR,
   input  wire [31:0] PWDATA,
   output reg  [31:0] PRDATA,
   output reg         PREADY,
   output reg         PSLVERR,
   // Supply and pin inputs
   input  wire        VBAT_OK,
   input  wire        VIO_UV,
   input  wire        SUPPLY_UV,
   input  wire        OVERTEMP,
   input  wire        HW_RESET_N,
   input  wire        ENABLE_PIN,
   input  wire        LOCAL_WAKE_EVENT,
   // Link status inputs
   input  wire        PCS_RX_DV,
   input  wire        TXEN,
   input  wire        WAKE_REQ_RX,
   input  wire        LOWPOWER_CODE_SEEN,
   input  wire        FRAME_ACTIVITY,
   input  wire        LINE_ACTIVITY,
   input  wire        LINE_QUIET,
   // Block controls
   output reg         MII_DRIVE_EN,
   output reg         MII_RX_FORCE_LOW,
   output reg         PCS_TX_EN,
   output reg         PCS_RX_EN,
   output reg         ACT_DETECT_EN,
   output reg         OSC_EN,
   output reg         CORE_REG_EN,
   output reg         REGULATOR_INHIBIT_OUT,
   output reg         INT_OUT_EN,
   output reg  [3:0]  MODE_CODE
);

   localparam [6:0] ST_OFF = 7'h01, ST_STANDBY = 7'h02, ST_NORMAL = 7'h04,
                    ST_SLEEPREQ = 7'h08, ST_SILENT = 7'h10, ST_SLEEP = 7'h20,
                    ST_DISABLE = 7'h40;

   // Two-stage synchronisers for all asynchronous pins
   reg  [13:0] sync1_reg;
   reg  [13:0] sync2_reg;
   always @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         sync1_reg <= 14'h0000;
         sync2_reg <= 14'h0000;
      end else begin
         sync1_reg <= {LINE_QUIET, LINE_ACTIVITY, FRAME_ACTIVITY, LOWPOWER_CODE_SEEN,
                       WAKE_REQ_RX, TXEN, PCS_RX_DV, LOCAL_WAKE_EVENT, ENABLE_PIN,
                       HW_RESET_N, OVERTEMP, SUPPLY_UV, VIO_UV, VBAT_OK};
         sync2_reg <= sync1_reg;
      end
   end
   wire vbat_ok    = sync2_reg[0];
   wire vio_uv     = sync2_reg[1];
   wire sup_uv     = sync2_reg[2];
   wire overtemp   = sync2_reg[3];
   wire hw_rst_n   = sync2_reg[4];
   wire enable_pin = sync2_reg[5];
   wire local_wake = sync2_reg[6];
   wire rx_dv      = sync2_reg[7];
   wire tx_en      = sync2_reg[8];
   wire wur_rx     = sync2_reg[9];
   wire lps_seen   = sync2_reg[10];
   wire frame_act  = sync2_reg[11];
   wire line_act   = sync2_reg[12];
   wire line_quiet = sync2_reg[13];

   reg  [6:0]  mode_reg;
   reg  [6:0]  mode_next;
   reg  [`POMC_CFG_W-1:0] cfg_reg;
   reg  [31:0] mode_tmr_reg;
   reg  [31:0] idle_tmr_reg;
   reg  [31:0] uv_tmr_reg;
   reg         uv_armed_reg;
   reg  [3:0]  code_now;

   wire in_sleep = mode_reg == ST_SLEEP;
   // Management is dead while disabled or unpowered
   wire smi_on   = !(mode_reg == ST_DISABLE || mode_reg == ST_OFF);
   wire setup    = PSEL && !PENABLE;
   wire access   = PSEL && PENABLE && PREADY;
   wire hit_mode = PADDR == `POMC_OFS_MODE;
   wire hit_cfg  = PADDR == `POMC_OFS_CFG;
   wire hit_stat = PADDR == `POMC_OFS_STATUS;
   wire mapped   = hit_mode || hit_cfg || hit_stat;
   // In Sleep only the Standby command gets through
   wire cmd_ok   = !in_sleep || PWDATA[3:0] == `POMC_CMD_STANDBY;
   wire cmd_wr   = access && PWRITE && hit_mode && smi_on && cmd_ok;
   wire cfg_wr   = access && PWRITE && hit_cfg && smi_on && !in_sleep;
   wire [3:0] cmd = PWDATA[3:0];

   wire lps_en    = !cfg_reg[`POMC_CFG_LPS_DIS];
   wire slp_ack   = cfg_reg[`POMC_CFG_SLP_ACK];
   wire req_exp   = mode_tmr_reg > REQ_CYC;
   wire ack_live  = mode_tmr_reg < ACK_CYC;
   wire idle_exp  = idle_tmr_reg > IDLE_CYC;
   wire uv_exp    = uv_armed_reg && uv_tmr_reg >= UV_CYC;
   wire wake_req  = (cfg_reg[`POMC_CFG_FWD_WAKE] && local_wake) || wur_rx;
   wire data_det  = rx_dv || tx_en;
   wire any_uv    = vio_uv || sup_uv;

   always @* begin
      mode_next = mode_reg;
      if (!vbat_ok) begin
         mode_next = ST_OFF;
      end else if (mode_reg == ST_OFF) begin
         mode_next = ST_STANDBY;
      end else if (vio_uv) begin
         mode_next = (uv_exp || in_sleep) ? ST_SLEEP : ST_STANDBY;
      end else if (!hw_rst_n && !in_sleep) begin
         mode_next = ST_STANDBY;
      end else if (!enable_pin && !in_sleep) begin
         mode_next = ST_DISABLE;
      end else if (mode_reg == ST_DISABLE) begin
         mode_next = ST_STANDBY;
      end else if (sup_uv || overtemp) begin
         mode_next = (uv_exp || in_sleep) ? ST_SLEEP : ST_STANDBY;
      end else begin
         case (mode_reg)
            ST_STANDBY: begin
               if (cmd_wr && cmd == `POMC_CMD_NORMAL) begin
                  mode_next = ST_NORMAL;
               end
            end
            ST_NORMAL: begin
               // Host may always fall back to Standby from an active mode
               if (cmd_wr && cmd == `POMC_CMD_SLEEPREQ) begin
                  mode_next = ST_SLEEPREQ;
               end else if (cmd_wr && cmd == `POMC_CMD_STANDBY) begin
                  mode_next = ST_STANDBY;
               end else if (cfg_reg[`POMC_CFG_IDLE_PD] && idle_exp) begin
                  mode_next = ST_SLEEPREQ;
               end else if (lps_en && lps_seen && cfg_reg[`POMC_CFG_LPS_HS] && req_exp) begin
                  mode_next = ST_SLEEPREQ;
               end
            end
            ST_SLEEPREQ: begin
               // Before the request timeout only persisting undervoltage leads to Sleep
               // Standby command is honoured even after the acknowledge window
               if (cmd_wr && cmd == `POMC_CMD_STANDBY) begin
                  mode_next = ST_STANDBY;
               end else if ((cmd_wr && cmd == `POMC_CMD_NORMAL) || wake_req) begin
                  if (!slp_ack || ack_live) begin
                     mode_next = ST_NORMAL;
                  end
               end else if (!slp_ack && data_det) begin
                  mode_next = ST_NORMAL;
               end else if (req_exp) begin
                  mode_next = lps_en ? ST_SILENT : ST_SLEEP;
               end
            end
            ST_SILENT: begin
               if (line_quiet) begin
                  mode_next = ST_SLEEP;
               end else if (req_exp) begin
                  mode_next = ST_NORMAL;
               end
            end
            ST_SLEEP: begin
               if ((cmd_wr && cmd == `POMC_CMD_STANDBY) || line_act) begin
                  mode_next = ST_STANDBY;
               end
            end
            default: mode_next = ST_OFF;
         endcase
      end
   end

   always @* begin
      case (mode_reg)
         ST_NORMAL:   code_now = `POMC_CODE_NORMAL;
         ST_STANDBY:  code_now = `POMC_CODE_STANDBY;
         ST_SLEEPREQ: code_now = `POMC_CODE_SLEEPREQ;
         ST_SILENT:   code_now = `POMC_CODE_SILENT;
         ST_SLEEP:    code_now = `POMC_CODE_SLEEP;
         ST_DISABLE:  code_now = `POMC_CODE_DISABLE;
         default:     code_now = `POMC_CODE_OFF;
      endcase
   end

   // Mode, timers and configuration
   always @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         mode_reg     <= ST_OFF;
         mode_tmr_reg <= 32'h00000000;
         idle_tmr_reg <= 32'h00000000;
         uv_tmr_reg   <= 32'h00000000;
         uv_armed_reg <= 1'b0;
         cfg_reg      <= `POMC_CFG_RST;
      end else begin
         mode_reg <= mode_next;
         if (mode_next != mode_reg) begin
            mode_tmr_reg <= 32'h00000000;
         end else if (mode_tmr_reg != 32'hFFFFFFFF) begin
            mode_tmr_reg <= mode_tmr_reg + 32'h00000001;
         end
         if (mode_reg != ST_NORMAL || frame_act) begin
            idle_tmr_reg <= 32'h00000000;
         end else if (idle_tmr_reg != 32'hFFFFFFFF) begin
            idle_tmr_reg <= idle_tmr_reg + 32'h00000001;
         end
         if (mode_reg == ST_OFF) begin
            uv_armed_reg <= 1'b0;
         end else if (!any_uv) begin
            uv_armed_reg <= 1'b1;
         end
         if (!any_uv || !uv_armed_reg) begin
            uv_tmr_reg <= 32'h00000000;
         end else if (uv_tmr_reg != 32'hFFFFFFFF) begin
            uv_tmr_reg <= uv_tmr_reg + 32'h00000001;
         end
         // Reset pin restores defaults, except in Sleep where it is ignored
         if (!vbat_ok || (!hw_rst_n && !in_sleep)) begin
            cfg_reg <= `POMC_CFG_RST;
         end else if (cfg_wr) begin
            cfg_reg <= PWDATA[`POMC_CFG_W-1:0];
         end
      end
   end

   // APB answer prepared in setup so the access phase completes at once
   always @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         PREADY  <= 1'b0;
         PSLVERR <= 1'b0;
         PRDATA  <= 32'h00000000;
      end else begin
         PREADY  <= setup;
         PSLVERR <= setup && !mapped;
         PRDATA  <= 32'h00000000;
         if (setup && smi_on) begin
            if (hit_mode) begin
               PRDATA <= {28'h0000000, code_now};
            end else if (hit_cfg && !in_sleep) begin
               PRDATA <= {22'h000000, cfg_reg};
            end else if (hit_stat && !in_sleep) begin
               PRDATA <= {17'h00000, uv_armed_reg, sync2_reg};
            end
         end
      end
   end

   // Block controls follow the mode being entered, MODE_CODE the current mode
   always @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         MII_DRIVE_EN          <= 1'b0;
         MII_RX_FORCE_LOW      <= 1'b0;
         PCS_TX_EN             <= 1'b0;
         PCS_RX_EN             <= 1'b0;
         ACT_DETECT_EN         <= 1'b0;
         OSC_EN                <= 1'b0;
         CORE_REG_EN           <= 1'b0;
         REGULATOR_INHIBIT_OUT <= 1'b0;
         INT_OUT_EN            <= 1'b0;
         MODE_CODE             <= `POMC_CODE_OFF;
      end else begin
         MII_DRIVE_EN     <= mode_next == ST_NORMAL || mode_next == ST_SLEEPREQ;
         PCS_TX_EN        <= mode_next == ST_NORMAL || mode_next == ST_SLEEPREQ;
         PCS_RX_EN        <= mode_next == ST_NORMAL || mode_next == ST_SLEEPREQ;
         MII_RX_FORCE_LOW <= mode_next == ST_STANDBY;
         ACT_DETECT_EN    <= mode_next == ST_STANDBY || mode_next == ST_SLEEP;
         case (mode_next)
            ST_NORMAL, ST_SLEEPREQ, ST_SILENT:
               OSC_EN <= !cfg_reg[`POMC_CFG_CLK_HI];
            ST_SLEEP:
               OSC_EN <= cfg_reg[`POMC_CFG_KEEP_CLK] && !cfg_reg[`POMC_CFG_CLK_HI];
            default:
               OSC_EN <= 1'b0;
         endcase
         CORE_REG_EN <= !cfg_reg[`POMC_CFG_CORE_SEL] && (mode_next == ST_NORMAL ||
                        mode_next == ST_STANDBY || mode_next == ST_SLEEPREQ ||
                        mode_next == ST_SILENT);
         case (mode_next)
            ST_NORMAL, ST_STANDBY, ST_SLEEPREQ, ST_SILENT:
               REGULATOR_INHIBIT_OUT <= 1'b1;
            ST_DISABLE:
               REGULATOR_INHIBIT_OUT <= cfg_reg[`POMC_CFG_INH_DIS];
            default:
               REGULATOR_INHIBIT_OUT <= 1'b0;
         endcase
         INT_OUT_EN <= mode_next == ST_NORMAL || mode_next == ST_STANDBY ||
                       mode_next == ST_SLEEPREQ || mode_next == ST_SILENT;
         MODE_CODE  <= code_now;
      end
   end

endmodule // pomc_top

/* File: pomc_top_tb.sv */
`timescale 1ns/1ps
module pomc_top_tb;
   logic        CLOCK, NRST, PSEL, PENABLE, PWRITE, se, VBAT_OK, VIO_UV, SUPPLY_UV, OVERTEMP;
   logic        HW_RESET_N, ENABLE_PIN, LOCAL_WAKE_EVENT, TXEN;
   logic [7:0]  PADDR;
   logic [31:0] PWDATA, rd;
   logic [2:0]  lnk;
   wire  [31:0] PRDATA;
   wire         PREADY, PSLVERR, PCS_RX_DV, WAKE_REQ_RX, LOWPOWER_CODE_SEEN, FRAME_ACTIVITY;
   wire         LINE_ACTIVITY, LINE_QUIET, MII_DRIVE_EN, MII_RX_FORCE_LOW, PCS_TX_EN, PCS_RX_EN;
   wire         ACT_DETECT_EN, OSC_EN, CORE_REG_EN, REGULATOR_INHIBIT_OUT, INT_OUT_EN;
   wire  [3:0]  MODE_CODE;
   wire  [8:0]  outs = {MII_DRIVE_EN, MII_RX_FORCE_LOW, PCS_TX_EN, PCS_RX_EN, ACT_DETECT_EN,
                        OSC_EN, CORE_REG_EN, REGULATOR_INHIBIT_OUT, INT_OUT_EN};
   int          fails = 0;
   int          n_tests = 0;
   // Rows: configuration, command (also the mode it gives), controls expected
   logic [9:0]  r_cfg [6] = '{10'h000, 10'h180, 10'h010, 10'h000, 10'h000, 10'h000};
   logic [3:0]  r_cmd [6] = '{4'h3, 4'h3, 4'h3, 4'hB, 4'h3, 4'hC};
   logic [8:0]  r_out [6] = '{9'h16F, 9'h167, 9'h16B, 9'h16F, 9'h16F, 9'h097};

   pomc_top #(.REQ_CYC(32'd20), .ACK_CYC(32'd10), .IDLE_CYC(32'd30), .UV_CYC(32'd40)) i_dut (
      .CLOCK(CLOCK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
      .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .VBAT_OK(VBAT_OK),
      .VIO_UV(VIO_UV), .SUPPLY_UV(SUPPLY_UV), .OVERTEMP(OVERTEMP), .HW_RESET_N(HW_RESET_N),
      .ENABLE_PIN(ENABLE_PIN), .LOCAL_WAKE_EVENT(LOCAL_WAKE_EVENT), .PCS_RX_DV(PCS_RX_DV),
      .TXEN(TXEN), .WAKE_REQ_RX(WAKE_REQ_RX), .LOWPOWER_CODE_SEEN(LOWPOWER_CODE_SEEN),
      .FRAME_ACTIVITY(FRAME_ACTIVITY), .LINE_ACTIVITY(LINE_ACTIVITY), .LINE_QUIET(LINE_QUIET),
      .MII_DRIVE_EN(MII_DRIVE_EN), .MII_RX_FORCE_LOW(MII_RX_FORCE_LOW), .PCS_TX_EN(PCS_TX_EN),
      .PCS_RX_EN(PCS_RX_EN), .ACT_DETECT_EN(ACT_DETECT_EN), .OSC_EN(OSC_EN),
      .CORE_REG_EN(CORE_REG_EN), .REGULATOR_INHIBIT_OUT(REGULATOR_INHIBIT_OUT),
      .INT_OUT_EN(INT_OUT_EN), .MODE_CODE(MODE_CODE));
   pomc_partner i_far (.clk(CLOCK), .lnk(lnk), .tx_on(PCS_TX_EN), .rx_dv(PCS_RX_DV),
      .wur(WAKE_REQ_RX), .lps(LOWPOWER_CODE_SEEN), .frames(FRAME_ACTIVITY),
      .activity(LINE_ACTIVITY), .quiet(LINE_QUIET));

   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge CLOCK);
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge CLOCK);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLOCK);
      PENABLE <= 1'b1;
      do @(posedge CLOCK); while (PREADY !== 1'b1);
      rd = PRDATA;
      se = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask
   // Bounded wait for a mode; zero cycles means check at once
   task automatic wmode(input logic [3:0] m, input int n);
      int i;
      for (i = 0; i < n && MODE_CODE !== m; i++) @(posedge CLOCK);
      chk("mode", {28'h0, MODE_CODE}, {28'h0, m});
   endtask
   // Fresh entry into Normal, so mode timers restart
   task automatic start(input logic [9:0] cfg, input logic [2:0] k);
      apb(1'b1, 8'h00, 32'h0000000C);
      lnk <= k;
      apb(1'b1, 8'h04, {22'h0, cfg});
      apb(1'b1, 8'h00, 32'h00000003);
      wmode(4'h3, 8);
   endtask

   initial begin
      CLOCK = 1'b0;
      forever #2.5 CLOCK = ~CLOCK;
   end
   // Whole run is under a thousand cycles; six thousand means a hang
   initial begin
      repeat (6000) @(posedge CLOCK);
      fails++;
      conclude();
   end
   initial begin
      {NRST, PSEL, PENABLE, PWRITE, PADDR, PWDATA, VIO_UV, SUPPLY_UV, OVERTEMP} = '0;
      {LOCAL_WAKE_EVENT, TXEN, lnk} = '0;
      {VBAT_OK, HW_RESET_N, ENABLE_PIN} = 3'h7;
      repeat (16) @(posedge CLOCK);
      chk("reset outputs", {19'h0, outs, MODE_CODE}, 32'h0);
      NRST <= 1'b1;
      wmode(4'hC, 10);
      for (int r = 0; r < 6; r++) begin
         apb(1'b1, 8'h04, {22'h0, r_cfg[r]});
         apb(1'b1, 8'h00, {28'h0, r_cmd[r]});
         cyc(2);
         chk("controls", {23'h0, outs}, {23'h0, r_out[r]});
         apb(1'b0, 8'h00, 32'h0);
         chk("mode read", rd, {28'h0, r_cmd[r]});
      end
      apb(1'b0, 8'h40, 32'h0);
      chk("unmapped", {rd[30:0], se}, 32'h1);
      for (int k = 0; k < 3; k++) begin
         start(10'h008, 3'h0);
         apb(1'b1, 8'h00, 32'h0000000B);
         wmode(4'hB, 4);
         if (k == 0) LOCAL_WAKE_EVENT <= 1'b1;
         else lnk <= (k == 1) ? 3'h3 : 3'h4;
         wmode(4'h3, 8);
         LOCAL_WAKE_EVENT <= 1'b0;
      end
      start(10'h001, 3'h0);
      cyc(20);
      wmode(4'h3, 0);
      wmode(4'hB, 20);
      start(10'h004, 3'h2);
      cyc(12);
      wmode(4'h3, 0);
      wmode(4'hB, 20);
      start(10'h200, 3'h1);
      apb(1'b1, 8'h00, 32'h0000000B);
      cyc(12);
      apb(1'b1, 8'h00, 32'h00000003);
      wmode(4'hB, 0);
      wmode(4'h9, 20);
      wmode(4'h3, 30);
      start(10'h042, 3'h0);
      apb(1'b1, 8'h00, 32'h0000000B);
      cyc(14);
      wmode(4'hB, 0);
      wmode(4'hA, 20);
      chk("sleep controls", {23'h0, outs}, 32'h018);
      apb(1'b0, 8'h04, 32'h0);
      chk("sleep cfg read", rd, 32'h0);
      apb(1'b1, 8'h00, 32'h00000003);
      HW_RESET_N <= 1'b0;
      cyc(6);
      wmode(4'hA, 0);
      HW_RESET_N <= 1'b1;
      apb(1'b0, 8'h00, 32'h0);
      chk("sleep mode read", rd, 32'hA);
      apb(1'b1, 8'h00, 32'h0000000C);
      wmode(4'hC, 4);
      start(10'h000, 3'h0);
      apb(1'b1, 8'h00, 32'h0000000B);
      wmode(4'h9, 30);
      wmode(4'hA, 20);
      lnk <= 3'h1;
      wmode(4'hC, 10);
      start(10'h020, 3'h0);
      ENABLE_PIN <= 1'b0;
      wmode(4'h1, 8);
      chk("disable controls", {23'h0, outs}, 32'h002);
      HW_RESET_N <= 1'b0;
      wmode(4'hC, 8);
      HW_RESET_N <= 1'b1;
      wmode(4'h1, 8);
      chk("disable no inhibit", {23'h0, outs}, 32'h0);
      ENABLE_PIN <= 1'b1;
      wmode(4'hC, 8);
      start(10'h000, 3'h0);
      OVERTEMP <= 1'b1;
      wmode(4'hC, 8);
      OVERTEMP <= 1'b0;
      SUPPLY_UV <= 1'b1;
      cyc(30);
      wmode(4'hC, 0);
      wmode(4'hA, 20);
      SUPPLY_UV <= 1'b0;
      conclude();
   end
endmodule // pomc_top_tb
